//--- src/ppp_pkg.sv
// Constants shared by the PROM programmer controller
package ppp_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned ADDR_W          = 13;
    localparam int unsigned DATA_W          = 8;
    localparam logic [12:0] LAST_ADDR       = 13'h1FFF;
    localparam int unsigned MAX_TRIES       = 25;
    // Times as printed, in nanoseconds
    localparam int unsigned PULSE_NS        = 1_000_000;
    localparam int unsigned OVER_UNIT_NS    = 3_000_000;
    localparam int unsigned SETUP_NS        = 2_000;
    localparam int unsigned OE_LOW_NS       = 2_000;
    localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
    // Least times round up to whole cycles
    localparam int unsigned PULSE_CYC       = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned OVER_UNIT_CYC   = (OVER_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned OE_LOW_CYC      = (OE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TIMER_W         = 22;
    localparam logic [4:0]  TRIES_RST       = 5'h00;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_SETUP  = 4'b0001,
        ST_PULSE  = 4'b0010,
        ST_HOLD   = 4'b0011,
        ST_VSETUP = 4'b0100,
        ST_VREAD  = 4'b0101,
        ST_OSETUP = 4'b0110,
        ST_OPULSE = 4'b0111,
        ST_OHOLD  = 4'b1000,
        ST_RSETUP = 4'b1001,
        ST_RREAD  = 4'b1010
    } ppp_state_type;
endpackage

//--- src/ppp_sync.sv
// Two flip-flop synchroniser for the data bus returning from the PROM
`timescale 1ns/10ps
`default_nettype none
module ppp_sync (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] async_in,
    output logic      [7:0] sync_out
);
    logic [7:0] meta_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 8'h00;
            sync_out <= 8'h00;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

//--- src/ppp_high_voltage_select.sv
// PROM programmer: write-verify-overprogram over the whole array, and single reads
// Contract
// R1 - Write/verify needs main supply 6 V, 12.5 V on select and program supply
// R2 - Pulse low writes, output enable low verifies, both high inhibits
// R3 - Never drive pulse strobe and output enable low together in write mode
// R4 - Read mode: 5 V on main and program supply, 12.5 V on select
// R5 - Read mode: output enable low makes device drive addressed byte
// R6 - Read mode: output enable high leaves data bus floating
// R7 - Present address and data, then one 1 ms low program pulse
// R8 - Verify after each pulse; retry up to 25 attempts, then fail and stop
// R9 - After pass, one extra pulse of 3 ms times attempts used
// R10 - Extra pulse must lie between 2.85 ms and 78.75 ms
// R11 - Increment address and repeat until last address is written
// R12 - Read: present address, hold output enable low at least 1 us
// R13 - Array is 8192 bytes with 13-bit address
// R14 - Data bus is bidirectional under strobe control
// R15 - Hold address and data stable over pulse; release bus before verify
// R16 - Report per-byte pass or fail; attempts reset at each new address
`timescale 1ns/10ps
`default_nettype none
module ppp_high_voltage_select (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        high_voltage_select_start,
    input  wire logic [7:0]  high_voltage_select_wdata,
    output logic             high_voltage_select_wready,
    input  wire logic        read_start,
    input  wire logic [12:0] read_addr,
    output logic             busy,
    output logic             byte_done,
    output logic             byte_pass,
    output logic             part_defective,
    output logic             array_done,
    output logic [7:0]       read_data,
    output logic             read_valid,
    output logic             supply_high_voltage_select_mode,
    output logic             supply_read_mode,
    output logic [12:0]      prom_address,
    output logic [7:0]       prom_data_bus_o,
    output logic             prom_data_bus_oe,
    input  wire logic [7:0]  prom_data_bus_i,
    output logic             high_voltage_select_pulse_n,
    output logic             out_enable_n
);
    ppp_pkg::ppp_state_type state_reg;
    logic [21:0] timer_reg;
    logic [4:0]  tries_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  din_sync;

    function automatic logic [21:0] cyc(input int unsigned n);
        return n[21:0];
    endfunction

    ppp_sync u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (prom_data_bus_i),
        .sync_out (din_sync)
    );

    wire timer_zero = (timer_reg == 22'h00_0000);

    // Sequencer; each wait state loads the timer on entry and leaves when it runs out
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ppp_pkg::ST_IDLE;
            timer_reg <= 22'h00_0000;
            tries_reg <= ppp_pkg::TRIES_RST;
            wdata_reg <= 8'h00;
            prom_address <= 13'h0000;
            busy <= 1'b0;
            byte_done <= 1'b0;
            byte_pass <= 1'b0;
            part_defective <= 1'b0;
            array_done <= 1'b0;
            read_data <= 8'h00;
            read_valid <= 1'b0;
            high_voltage_select_wready <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            read_valid <= 1'b0;
            array_done <= 1'b0;
            high_voltage_select_wready <= 1'b0;
            if (!timer_zero) begin
                timer_reg <= timer_reg - 22'h00_0001;
            end
            unique case (state_reg)
                ppp_pkg::ST_IDLE: begin
                    busy <= 1'b0;
                    if (high_voltage_select_start) begin
                        busy <= 1'b1;
                        part_defective <= 1'b0;
                        prom_address <= 13'h0000;
                        tries_reg <= ppp_pkg::TRIES_RST;  // see R16
                        wdata_reg <= high_voltage_select_wdata;
                        high_voltage_select_wready <= 1'b1;
                        timer_reg <= cyc(ppp_pkg::SETUP_CYC);
                        state_reg <= ppp_pkg::ST_SETUP;
                    end else if (read_start) begin
                        busy <= 1'b1;
                        prom_address <= read_addr;  // see R12
                        timer_reg <= cyc(ppp_pkg::SETUP_CYC);
                        state_reg <= ppp_pkg::ST_RSETUP;
                    end
                end
                ppp_pkg::ST_SETUP: if (timer_zero) begin
                    tries_reg <= tries_reg + 5'h01;
                    timer_reg <= cyc(ppp_pkg::PULSE_CYC);  // see R7
                    state_reg <= ppp_pkg::ST_PULSE;
                end
                ppp_pkg::ST_PULSE: if (timer_zero) begin
                    timer_reg <= cyc(ppp_pkg::SETUP_CYC);  // see R15
                    state_reg <= ppp_pkg::ST_HOLD;
                end
                ppp_pkg::ST_HOLD: if (timer_zero) begin
                    timer_reg <= cyc(ppp_pkg::SETUP_CYC);
                    state_reg <= ppp_pkg::ST_VSETUP;
                end
                ppp_pkg::ST_VSETUP: if (timer_zero) begin
                    // Extra margin covers the two synchroniser stages
                    timer_reg <= cyc(ppp_pkg::OE_LOW_CYC);
                    state_reg <= ppp_pkg::ST_VREAD;
                end
                ppp_pkg::ST_VREAD: if (timer_zero) begin
                    if (din_sync == wdata_reg) begin
                        // Overprogram length scales with attempts used
                        timer_reg <= cyc(ppp_pkg::SETUP_CYC);  // see R9
                        state_reg <= ppp_pkg::ST_OSETUP;
                    end else if (tries_reg >= 5'(ppp_pkg::MAX_TRIES)) begin
                        byte_done <= 1'b1;  // see R8
                        byte_pass <= 1'b0;  // see R16
                        part_defective <= 1'b1;
                        state_reg <= ppp_pkg::ST_IDLE;
                    end else begin
                        timer_reg <= cyc(ppp_pkg::SETUP_CYC);  // see R8
                        state_reg <= ppp_pkg::ST_SETUP;
                    end
                end
                ppp_pkg::ST_OSETUP: if (timer_zero) begin
                    // 3 ms x up to 25 stays inside 2.85..78.75 ms
                    timer_reg <= 22'(ppp_pkg::OVER_UNIT_CYC * tries_reg);  // see R10
                    state_reg <= ppp_pkg::ST_OPULSE;
                end
                ppp_pkg::ST_OPULSE: if (timer_zero) begin
                    timer_reg <= cyc(ppp_pkg::SETUP_CYC);
                    state_reg <= ppp_pkg::ST_OHOLD;
                end
                ppp_pkg::ST_OHOLD: if (timer_zero) begin
                    byte_done <= 1'b1;
                    byte_pass <= 1'b1;  // see R16
                    tries_reg <= ppp_pkg::TRIES_RST;  // see R16
                    if (prom_address == ppp_pkg::LAST_ADDR) begin
                        array_done <= 1'b1;  // see R11
                        state_reg <= ppp_pkg::ST_IDLE;
                    end else begin
                        prom_address <= prom_address + 13'h0001;  // see R11
                        wdata_reg <= high_voltage_select_wdata;
                        high_voltage_select_wready <= 1'b1;
                        timer_reg <= cyc(ppp_pkg::SETUP_CYC);
                        state_reg <= ppp_pkg::ST_SETUP;
                    end
                end
                ppp_pkg::ST_RSETUP: if (timer_zero) begin
                    timer_reg <= cyc(ppp_pkg::OE_LOW_CYC);  // see R12
                    state_reg <= ppp_pkg::ST_RREAD;
                end
                ppp_pkg::ST_RREAD: if (timer_zero) begin
                    read_data <= din_sync;  // see R5
                    read_valid <= 1'b1;
                    state_reg <= ppp_pkg::ST_IDLE;
                end
                default: state_reg <= ppp_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin drive; strobes registered from the state so they never glitch
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            high_voltage_select_pulse_n <= 1'b1;
            out_enable_n <= 1'b1;
            prom_data_bus_o <= 8'h00;
            prom_data_bus_oe <= 1'b0;
            supply_high_voltage_select_mode <= 1'b0;
            supply_read_mode <= 1'b0;
        end else begin
            high_voltage_select_pulse_n <= !(state_reg == ppp_pkg::ST_PULSE ||
                              state_reg == ppp_pkg::ST_OPULSE);  // see R2
            out_enable_n <= !(state_reg == ppp_pkg::ST_VREAD ||
                              state_reg == ppp_pkg::ST_RREAD);  // see R3
            prom_data_bus_o <= wdata_reg;
            // Bus driven only around write pulses; released before verify
            prom_data_bus_oe <= (state_reg == ppp_pkg::ST_SETUP ||
                                 state_reg == ppp_pkg::ST_PULSE ||
                                 state_reg == ppp_pkg::ST_HOLD ||
                                 state_reg == ppp_pkg::ST_OSETUP ||
                                 state_reg == ppp_pkg::ST_OPULSE ||
                                 state_reg == ppp_pkg::ST_OHOLD);  // see R14
            supply_high_voltage_select_mode <= busy && state_reg != ppp_pkg::ST_RSETUP &&
                                state_reg != ppp_pkg::ST_RREAD &&
                                state_reg != ppp_pkg::ST_IDLE;  // see R1
            supply_read_mode <= state_reg == ppp_pkg::ST_RSETUP ||
                                state_reg == ppp_pkg::ST_RREAD;  // see R4
        end
    end

    a_strobe_excl: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R3
        !(!high_voltage_select_pulse_n && !out_enable_n))
        else $error("pulse and output enable low together");
    a_bus_release: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R15
        !out_enable_n |-> !prom_data_bus_oe)
        else $error("bus driven during output enable");
    a_pulse_len: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R7
        $fell(high_voltage_select_pulse_n) && state_reg == ppp_pkg::ST_PULSE |->
        !high_voltage_select_pulse_n [*8])
        else $error("program pulse too short");
    a_addr_stable: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R15
        !high_voltage_select_pulse_n && !$fell(high_voltage_select_pulse_n) |-> $stable(prom_address))
        else $error("address moved during pulse");
    a_tries_max: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R8
        tries_reg <= 5'(ppp_pkg::MAX_TRIES))
        else $error("too many attempts");
    a_fail_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R8
        byte_done && !byte_pass |-> ##1 state_reg == ppp_pkg::ST_IDLE)
        else $error("write continued after failure");
    a_over_nonzero: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R9
        state_reg == ppp_pkg::ST_OSETUP |-> tries_reg != 5'h00)
        else $error("overprogram with no attempts");
    a_read_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R4
        supply_read_mode |-> !supply_high_voltage_select_mode && high_voltage_select_pulse_n)
        else $error("read mode with write strobes");
    a_pass_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see R16
        byte_done && byte_pass |-> ##1 tries_reg == 5'h00)
        else $error("attempts not reset");
    c_read: cover property (@(posedge sys_clk) read_valid);
    c_pass: cover property (@(posedge sys_clk) byte_done && byte_pass);
    c_fail: cover property (@(posedge sys_clk) part_defective);
    c_retry: cover property (@(posedge sys_clk)
        state_reg == ppp_pkg::ST_VREAD ##1 state_reg == ppp_pkg::ST_SETUP);
endmodule
`default_nettype wire

//--- sim/ppp_prom_model.sv
// Behavioural PROM device answering the programmer controller
`timescale 1ns/10ps
`default_nettype none
module ppp_prom_model #(
    parameter int ACCESS_NS = 900
) (
    input  wire logic        supply_high_voltage_select_mode,
    input  wire logic        supply_read_mode,
    input  wire logic [12:0] prom_address,
    input  wire logic [7:0]  prom_data_bus_o,
    input  wire logic        prom_data_bus_oe,
    output logic      [7:0]  prom_data_bus_i,
    input  wire logic        high_voltage_select_pulse_n,
    input  wire logic        out_enable_n
);
    logic [7:0]  mem [0:8191];
    logic [7:0]  last_q;
    logic [7:0]  data_q;
    logic [12:0] addr_q;
    logic        drive_q;
    logic        pulse_low;
    logic        oe_low;
    realtime     t_fall;
    realtime     t_oe;
    realtime     width [0:3];
    int          pulse_cnt;
    int          fault_cnt;

    initial begin
        last_q = 8'h00;
        drive_q = 1'b0;
        pulse_low = 1'b0;
        oe_low = 1'b0;
        pulse_cnt = 0;
        fault_cnt = 0;
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 5);
        end
    end

    // Pulsing outside programming supplies or with the bus undriven would corrupt the cell
    always @(negedge high_voltage_select_pulse_n) begin
        pulse_low = 1'b1;
        t_fall = $realtime;
        addr_q = prom_address;
        data_q = prom_data_bus_o;
        pulse_cnt++;
        if (!supply_high_voltage_select_mode || supply_read_mode || oe_low || !prom_data_bus_oe) begin
            fault_cnt++;
        end
    end

    always @(posedge high_voltage_select_pulse_n) begin
        if (pulse_low) begin
            if (pulse_cnt <= 4) begin
                width[pulse_cnt - 1] = $realtime - t_fall;
            end
            if (supply_high_voltage_select_mode && prom_address == addr_q && prom_data_bus_o == data_q) begin
                mem[addr_q] = data_q;
            end else begin
                fault_cnt++;
            end
        end
        pulse_low = 1'b0;
    end

    // Stale junk shows on the lines until the access time has passed
    always @(negedge out_enable_n) begin
        oe_low = 1'b1;
        t_oe = $realtime;
        if (pulse_low || supply_high_voltage_select_mode == supply_read_mode || prom_data_bus_oe) begin
            fault_cnt++;
        end
        #(ACCESS_NS);
        drive_q = oe_low && (supply_read_mode || !pulse_low);
    end

    always @(posedge out_enable_n) begin
        if (oe_low && supply_read_mode && $realtime - t_oe < 1000.0) begin
            fault_cnt++;
        end
        if (drive_q) begin
            last_q = mem[prom_address];
        end
        drive_q = 1'b0;
        oe_low = 1'b0;
    end

    assign prom_data_bus_i = prom_data_bus_oe ? prom_data_bus_o :
                             (drive_q ? mem[prom_address] : ~last_q);
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the PROM programmer controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        sys_clk, sys_rst, high_voltage_select_start, high_voltage_select_wready, read_start, busy, byte_done;
    logic        byte_pass, part_defective, array_done, read_valid, supply_high_voltage_select_mode;
    logic        supply_read_mode, prom_data_bus_oe, high_voltage_select_pulse_n, out_enable_n;
    logic [7:0]  high_voltage_select_wdata, read_data, prom_data_bus_o, prom_data_bus_i, exp_v, wdat;
    logic [12:0] read_addr, prom_address, a;
    logic [31:0] seed;
    logic [7:0]  exp_q [$];
    int          error_cnt, num_checks, n;

    ppp_high_voltage_select ppp_high_voltage_select_inst (.sys_clk, .sys_rst, .high_voltage_select_start, .high_voltage_select_wdata, .high_voltage_select_wready,
        .read_start, .read_addr, .busy, .byte_done, .byte_pass, .part_defective,
        .array_done, .read_data, .read_valid, .supply_high_voltage_select_mode, .supply_read_mode,
        .prom_address, .prom_data_bus_o, .prom_data_bus_oe, .prom_data_bus_i,
        .high_voltage_select_pulse_n, .out_enable_n);
    ppp_prom_model ppp_prom_model_inst (.supply_high_voltage_select_mode, .supply_read_mode, .prom_address,
        .prom_data_bus_o, .prom_data_bus_oe, .prom_data_bus_i, .high_voltage_select_pulse_n, .out_enable_n);

    function automatic logic [7:0] pat(input logic [12:0] x);
        return x[7:0] ^ x[12:5];
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
        num_checks++;
        if (seen !== expd) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, expd, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Selector instead of a ref argument keeps the task portable across simulators
    function automatic logic pick(input int sel);
        return (sel == 0) ? busy : ((sel == 1) ? high_voltage_select_wready : byte_done);
    endfunction

    task automatic wait_sig(input int sel, input logic val, input int lim, input string name);
        int   k;
        logic s;
        k = 0;
        s = pick(sel);
        while (s !== val && k < lim) begin
            @(negedge sys_clk);
            k++;
            s = pick(sel);
        end
        check(name, 32'(s), 32'(val));
    endtask

    // Busy may rise a cycle late, so give it time before waiting for its fall
    task automatic do_read(input logic [12:0] x, input logic [7:0] e);
        @(posedge sys_clk);
        read_start <= 1'b1;
        read_addr <= x;
        exp_q.push_back(e);
        @(posedge sys_clk);
        read_start <= 1'b0;
        repeat (3) @(negedge sys_clk);
        wait_sig(0, 1'b0, 400, "busy_end");
    endtask

    always @(negedge sys_clk) begin
        if (read_valid === 1'b1 || byte_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare_result", 32'd1, 32'd0);
            end else begin
                exp_v = exp_q.pop_front();
                if (read_valid === 1'b1) begin
                    check("read_data", 32'(read_data), 32'(exp_v));
                end else begin
                    check("byte_pass", 32'(byte_pass), 32'd1);
                    check("defective", 32'(part_defective), 32'd0);
                    check("array_done", 32'(array_done), 32'd0);
                    check("stored", 32'(ppp_prom_model_inst.mem[0]), 32'(exp_v));
                end
            end
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (150000) @(posedge sys_clk);
        error_cnt++;
        $display("wrong value watchdog expected done seen hang");
        test_done();
    end

    initial begin
        seed = 32'h9141_6df6;
        sys_rst = 1'b1;
        high_voltage_select_start = 1'b0;
        read_start = 1'b0;
        read_addr = 13'h0000;
        high_voltage_select_wdata = 8'h00;
        error_cnt = 0;
        num_checks = 0;
        repeat (6) @(posedge sys_clk);
        check("reset_strobes", 32'({high_voltage_select_pulse_n, out_enable_n, prom_data_bus_oe}), 32'h6);
        sys_rst <= 1'b0;
        do_read(13'h1fff, pat(13'h1fff));
        repeat (4) begin
            a = 13'($random(seed));
            do_read(a, pat(a));
        end
        @(posedge sys_clk);
        high_voltage_select_wdata <= 8'($random(seed));
        high_voltage_select_start <= 1'b1;
        @(posedge sys_clk);
        high_voltage_select_start <= 1'b0;
        wait_sig(1, 1'b1, 400, "wready");
        wdat = high_voltage_select_wdata;
        exp_q.push_back(wdat);
        // A read request while programming is ignored
        @(posedge sys_clk);
        high_voltage_select_wdata <= ~wdat;
        read_start <= 1'b1;
        @(posedge sys_clk);
        read_start <= 1'b0;
        wait_sig(2, 1'b1, 110000, "byte_done");
        n = 0;
        while (prom_address !== 13'h0001 && n < 80000) begin
            @(negedge sys_clk);
            n++;
        end
        check("next_address", 32'(prom_address), 32'h1);
        check("pulses", ppp_prom_model_inst.pulse_cnt, 32'd2);
        check("first_pulse", 32'(ppp_prom_model_inst.width[0] >= 950000.0 &&
            ppp_prom_model_inst.width[0] <= 1050000.0), 32'd1);
        check("over_pulse", 32'(ppp_prom_model_inst.width[1] >= 2850000.0 &&
            ppp_prom_model_inst.width[1] <= 3150000.0), 32'd1);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        @(negedge sys_clk);
        check("abort_idle", 32'({high_voltage_select_pulse_n, out_enable_n, prom_data_bus_oe, busy,
            supply_high_voltage_select_mode}), 32'h18);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        do_read(13'h0000, wdat);
        check("device_faults", ppp_prom_model_inst.fault_cnt, 32'd0);
        test_done();
    end
endmodule
`default_nettype wire
